// *** design/tmcic_regs.vh ***
// Register map, field positions, reset values and codes of the timer config block
`ifndef TMCIC_REGS_VH
`define TMCIC_REGS_VH

// Register addresses (word index on the plain port)
`define TMCIC_MODE0 5'h00
`define TMCIC_IOAB0 5'h05
`define TMCIC_IOCD0 5'h0a
`define TMCIC_IOCD3 5'h0b
`define TMCIC_IOCD4 5'h0c
`define TMCIC_CKS1 5'h0d

// Mode register layout
`define TMCIC_MODE_RST 8'hc0
`define TMCIC_MODE_FIXED 2'h3
`define TMCIC_BFB_BIT 5
`define TMCIC_BFA_BIT 4
`define TMCIC_MD_MSB 3
`define TMCIC_MD_LSB 0
`define TMCIC_MD_RST 4'h0
`define TMCIC_BF_RST 1'b0

// I/O control register layout
`define TMCIC_IO_RST 8'h00
`define TMCIC_IOHI_MSB 7
`define TMCIC_IOHI_LSB 4
`define TMCIC_IOLO_MSB 3
`define TMCIC_IOLO_LSB 0
`define TMCIC_CKS_RST 3'h0

// Mode field codes
`define TMCIC_MD_NORMAL 4'h0
`define TMCIC_MD_PWM1 4'h2
`define TMCIC_MD_PWM2 4'h3
`define TMCIC_MD_PHASE1 4'h4
`define TMCIC_MD_PHASE2 4'h5
`define TMCIC_MD_PHASE3 4'h6
`define TMCIC_MD_PHASE4 4'h7
`define TMCIC_MD_RSYNC 4'h8
`define TMCIC_MD_CPWM_PEAK 4'hd
`define TMCIC_MD_CPWM_VALLEY 4'he
`define TMCIC_MD_CPWM_BOTH 4'hf

// Clock-select codes
`define TMCIC_CKS_DIV1 3'h0
`define TMCIC_CKS_DIV4 3'h1
`define TMCIC_CKS_DIV16 3'h2
`define TMCIC_CKS_DIV64 3'h3
`define TMCIC_CKS_C4 3'h4
`define TMCIC_CKS_C5 3'h5
`define TMCIC_CKS_C6 3'h6
`define TMCIC_CKS_C7 3'h7

// Prescaler bits that must all be one for each divided tick
`define TMCIC_DIV4_BITS 2
`define TMCIC_DIV16_BITS 4
`define TMCIC_DIV64_BITS 6
`define TMCIC_DIV256_BITS 8
`define TMCIC_DIV1024_BITS 10

`endif

// *** design/tmcic_io_decode.v ***
// Decoder of one 4-bit I/O control field into compare and capture controls
`default_nettype none

module tmcic_io_decode (
    input wire [3:0] field_i,
    output wire cmp_en_o,
    output wire init_lvl_o,
    output wire [1:0] cmp_act_o,
    output wire cap_en_o,
    output wire [1:0] cap_edge_o
);

    // Output compare: top bit low, action 00 means pin output disabled
    assign cmp_en_o = ~field_i[3] & (|field_i[1:0]);
    // Initial pin level, held even while the action is disabled
    assign init_lvl_o = ~field_i[3] & field_i[2];
    // 01 drive 0, 10 drive 1, 11 toggle
    assign cmp_act_o = field_i[3] ? 2'h0 : field_i[1:0];

    // Pin capture: top bit high with bit 2 low; 1x codes other sources
    assign cap_en_o = field_i[3] & ~field_i[2];
    // 00 rising, 01 falling, 10 both edges
    assign cap_edge_o = cap_en_o ? {field_i[1], ~field_i[1] & field_i[0]} : 2'h0;

endmodule

`default_nettype wire

// *** design/tmcic_top.v ***
// Clock-source, mode and I/O control configuration of a five-channel timer
// Summary of operation
// - Codes 000-011 pick divide 1/4/16/64.
// - Channel 1 upper codes: A, B, /256, ch2 wrap.
// - Channel 2 upper codes: A, B, C, /1024.
// - Channels 3,4 upper codes: /256, /1024, A, B.
// - Phase counting overrides clock select, channels 1,2.
// - Mode register loads c0 on power-on/standby only.
// - Mode bits 7,6 read one, ignore writes.
// - Bit 5 buffers B with D, D silenced.
// - Bit 4 buffers A with C, C silenced.
// - Channels 1,2 bits 5,4 read zero, fixed.
// - Mode 0000 normal, 0010 PWM1, 0011 PWM2.
// - Modes 0100-0111 are phase counting 1-4.
// - 1000 reset-sync PWM; 1101-1111 complementary variants.
// - No PWM2 on 3,4; phase only 1,2.
// - Synchronous PWM only ch3; ch4 then follows.
// - I/O control clears on power-on/standby only.
// - First I/O register: high B, low A.
// - Channels 0,3,4: second register, high D, low C.
// - Buffering C or D ignores its I/O field.
// - Bit3 zero: compare, level, action.
// - Bit3 one, bit2 zero: pin capture edges.
`default_nettype none
`include "tmcic_regs.vh"

module tmcic_top #(
    parameter PRESC_W = 10
) (
    input wire mclk_i,
    input wire sys_rst_i,
    input wire standby_i,
    input wire manual_rst_i,
    input wire [4:0] addr_i,
    input wire [7:0] wdata_i,
    input wire wr_i,
    input wire rd_i,
    output wire [7:0] rdata_o,
    input wire ext_clock_pin_a_i,
    input wire ext_clock_pin_b_i,
    input wire ext_clock_pin_c_i,
    input wire channel2_count_wrap_i,
    input wire [1:0] phase_cnt_i,
    output wire [3:0] count_en_o,
    output wire [19:0] mode_field_o,
    output wire [4:0] buffer_pair_a_o,
    output wire [4:0] buffer_pair_b_o,
    output wire ch4_follow_o,
    output wire [19:0] cmp_en_o,
    output wire [19:0] init_lvl_o,
    output wire [39:0] cmp_act_o,
    output wire [19:0] cap_en_o,
    output wire [39:0] cap_edge_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations

    reg [19:0] md_ff; // Stored mode fields, channel n at [4n+3:4n]
    reg [4:0] bfa_ff; // Buffer bits A; only 0,3,4 ever set
    reg [4:0] bfb_ff; // Buffer bits B; only 0,3,4 ever set
    reg [39:0] ioab_ff; // First I/O register per channel
    reg [23:0] iocd_ff; // Second I/O register of channels 0,3,4
    reg [11:0] cks_ff; // Clock selects of channels 1..4
    reg [PRESC_W-1:0] presc_ff; // Shared free-running prescaler
    reg [2:0] sync1_ff; // First synchroniser stage, pins A,B,C
    reg [2:0] sync2_ff; // Second synchroniser stage
    reg [2:0] sync3_ff; // Delayed copy for edge detection
    reg [7:0] rdata_ff; // Read data, one cycle after the strobe
    reg [7:0] nxt_rdata; // Read mux result
    reg [3:0] cnt_en_ff; // Registered count enables
    reg [3:0] nxt_cnt_en;
    reg [19:0] eff_md_ff; // Effective modes after legality checks
    reg [19:0] nxt_eff_md;
    reg [4:0] bfa_out_ff;
    reg [4:0] bfb_out_ff;
    reg follow_ff;
    reg nxt_follow;
    reg [79:0] fld_val; // Effective I/O fields, 4 per channel
    reg [19:0] cmp_en_ff;
    reg [19:0] init_lvl_ff;
    reg [39:0] cmp_act_ff;
    reg [19:0] cap_en_ff;
    reg [39:0] cap_edge_ff;
    reg [2:0] sel; // Clock select under decode
    reg sel_en; // Enable chosen for one channel
    wire [19:0] dec_cmp_en;
    wire [19:0] dec_init_lvl;
    wire [39:0] dec_cmp_act;
    wire [19:0] dec_cap_en;
    wire [39:0] dec_cap_edge;
    wire [2:0] ext_rise; // One-cycle pulses on pin rising edges
    wire tick1;
    wire tick4;
    wire tick16;
    wire tick64;
    wire tick256;
    wire tick1024;
    wire cfg_rst; // Power-on reset or standby entry
    wire [3:0] md3_eff;
    integer i;
    integer k;
    integer j, m, n;

    // Manual reset absent so configuration survives it
    assign cfg_rst = sys_rst_i | standby_i;

    ////////////////////////////////////////////////////////////////////////////
    // Legality of a mode code on a given channel

    // Unavailable or reserved codes fall back to normal operation
    function [3:0] legal_md;
        input [2:0] ch;
        input [3:0] md;
        reg ok;
        begin
            case (md)
                `TMCIC_MD_NORMAL, `TMCIC_MD_PWM1: ok = 1'b1;
                `TMCIC_MD_PWM2: ok = (ch != 3'h3) && (ch != 3'h4);
                `TMCIC_MD_PHASE1, `TMCIC_MD_PHASE2,
                `TMCIC_MD_PHASE3, `TMCIC_MD_PHASE4: begin
                    ok = (ch == 3'h1) || (ch == 3'h2);
                end
                `TMCIC_MD_RSYNC, `TMCIC_MD_CPWM_PEAK,
                `TMCIC_MD_CPWM_VALLEY, `TMCIC_MD_CPWM_BOTH: begin
                    ok = (ch == 3'h3);
                end
                default: ok = 1'b0; // Reserved codes; hardware stays safe
            endcase
            legal_md = ok ? md : `TMCIC_MD_NORMAL;
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // Configuration registers

    // Writes land at the edge of the strobe; reserved bits never stored
    always @(posedge mclk_i) begin
        if (cfg_rst) begin
            md_ff <= {5{`TMCIC_MD_RST}};
            bfa_ff <= {5{`TMCIC_BF_RST}};
            bfb_ff <= {5{`TMCIC_BF_RST}};
            ioab_ff <= {5{`TMCIC_IO_RST}};
            iocd_ff <= {3{`TMCIC_IO_RST}};
            cks_ff <= {4{`TMCIC_CKS_RST}};
        end else if (wr_i) begin
            for (i = 0; i < 5; i = i + 1) begin
                // Bits 7,6 are not stored at all
                if (addr_i == `TMCIC_MODE0 + i[4:0]) begin
                    md_ff[4*i +: 4] <= wdata_i[`TMCIC_MD_MSB:`TMCIC_MD_LSB];
                    // Channels 1,2 have no C or D, so bits stay zero
                    if (i == 0 || i == 3 || i == 4) begin
                        bfa_ff[i] <= wdata_i[`TMCIC_BFA_BIT];
                        bfb_ff[i] <= wdata_i[`TMCIC_BFB_BIT];
                    end
                end
                // First I/O register exists on every channel
                if (addr_i == `TMCIC_IOAB0 + i[4:0]) begin
                    ioab_ff[8*i +: 8] <= wdata_i;
                end
            end
            // Second I/O register only on channels 0, 3, 4
            if (addr_i == `TMCIC_IOCD0) begin
                iocd_ff[7:0] <= wdata_i;
            end
            if (addr_i == `TMCIC_IOCD3) begin
                iocd_ff[15:8] <= wdata_i;
            end
            if (addr_i == `TMCIC_IOCD4) begin
                iocd_ff[23:16] <= wdata_i;
            end
            // Clock selects of channels 1..4
            for (i = 0; i < 4; i = i + 1) begin
                if (addr_i == `TMCIC_CKS1 + i[4:0]) begin
                    cks_ff[3*i +: 3] <= wdata_i[2:0];
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Register read path

    // Unmapped addresses read zero
    always @* begin
        nxt_rdata = 8'h00;
        for (j = 0; j < 5; j = j + 1) begin
            if (addr_i == `TMCIC_MODE0 + j[4:0]) begin
                // Fixed ones on top; buffer bits masked on channels 1,2
                if (j == 1 || j == 2) begin
                    nxt_rdata = {`TMCIC_MODE_FIXED, 2'h0, md_ff[4*j +: 4]};
                end else begin
                    nxt_rdata = {`TMCIC_MODE_FIXED, bfb_ff[j], bfa_ff[j],
                                 md_ff[4*j +: 4]};
                end
            end
            if (addr_i == `TMCIC_IOAB0 + j[4:0]) begin
                nxt_rdata = ioab_ff[8*j +: 8];
            end
        end
        for (j = 0; j < 3; j = j + 1) begin
            if (addr_i == `TMCIC_IOCD0 + j[4:0]) begin
                nxt_rdata = iocd_ff[8*j +: 8];
            end
        end
        for (j = 0; j < 4; j = j + 1) begin
            if (addr_i == `TMCIC_CKS1 + j[4:0]) begin
                nxt_rdata = {5'h00, cks_ff[3*j +: 3]};
            end
        end
    end

    // Data stands only in the cycle after the read strobe
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            rdata_ff <= 8'h00;
        end else if (rd_i) begin
            rdata_ff <= nxt_rdata;
        end else begin
            rdata_ff <= 8'h00;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Shared prescaler and pin edge detection

    // Free running; a manual reset restarts the divided ticks
    always @(posedge mclk_i) begin
        if (sys_rst_i || manual_rst_i) begin
            presc_ff <= {PRESC_W{1'b0}};
        end else begin
            presc_ff <= presc_ff + {{(PRESC_W-1){1'b0}}, 1'b1};
        end
    end

    // Each tick is high for one cycle in every 2^n
    assign tick1 = 1'b1;
    assign tick4 = &presc_ff[`TMCIC_DIV4_BITS-1:0];
    assign tick16 = &presc_ff[`TMCIC_DIV16_BITS-1:0];
    assign tick64 = &presc_ff[`TMCIC_DIV64_BITS-1:0];
    assign tick256 = &presc_ff[`TMCIC_DIV256_BITS-1:0];
    assign tick1024 = &presc_ff[`TMCIC_DIV1024_BITS-1:0];

    // Pins are asynchronous: two stages before any edge logic
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            sync1_ff <= 3'h0;
            sync2_ff <= 3'h0;
            sync3_ff <= 3'h0;
        end else begin
            sync1_ff <= {ext_clock_pin_c_i, ext_clock_pin_b_i, ext_clock_pin_a_i};
            sync2_ff <= sync1_ff;
            sync3_ff <= sync2_ff;
        end
    end

    // Rising edges only; edge choice lives in the counter control logic
    assign ext_rise = sync2_ff & ~sync3_ff;

    ////////////////////////////////////////////////////////////////////////////
    // Clock-source decode for channels 1..4

    // Effective mode of channel 3 drives the follow decision
    assign md3_eff = legal_md(3'h3, md_ff[15:12]);

    // One enable per channel picked by its clock-select code
    always @* begin
        nxt_cnt_en = 4'h0;
        sel = `TMCIC_CKS_RST;
        sel_en = 1'b0;
        for (k = 0; k < 4; k = k + 1) begin
            sel = cks_ff[3*k +: 3];
            case (sel)
                `TMCIC_CKS_DIV1: sel_en = tick1;
                `TMCIC_CKS_DIV4: sel_en = tick4;
                `TMCIC_CKS_DIV16: sel_en = tick16;
                `TMCIC_CKS_DIV64: sel_en = tick64;
                `TMCIC_CKS_C4: begin
                    sel_en = (k >= 2) ? tick256 : ext_rise[0];
                end
                `TMCIC_CKS_C5: begin
                    sel_en = (k >= 2) ? tick1024 : ext_rise[1];
                end
                `TMCIC_CKS_C6: begin
                    if (k == 0) begin
                        sel_en = tick256;
                    end else if (k == 1) begin
                        sel_en = ext_rise[2];
                    end else begin
                        sel_en = ext_rise[0];
                    end
                end
                `TMCIC_CKS_C7: begin
                    if (k == 0) begin
                        sel_en = channel2_count_wrap_i;
                    end else if (k == 1) begin
                        sel_en = tick1024;
                    end else begin
                        sel_en = ext_rise[1];
                    end
                end
                default: sel_en = 1'b0;
            endcase
            // Phase counting on channels 1,2 ignores the select field
            if (k < 2 && nxt_eff_md[4*(k+1)+3 -: 2] == 2'h1) begin
                sel_en = phase_cnt_i[k];
            end
            nxt_cnt_en[k] = sel_en;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Effective modes and I/O fields

    // Channel 4 is taken over while channel 3 runs a synchronous PWM
    always @* begin
        nxt_follow = (md3_eff == `TMCIC_MD_RSYNC) || (md3_eff[3:2] == 2'h3);
        for (m = 0; m < 4; m = m + 1) begin
            nxt_eff_md[4*m +: 4] = legal_md(m[2:0], md_ff[4*m +: 4]);
        end
        if (nxt_follow) begin
            nxt_eff_md[19:16] = md3_eff;
        end else begin
            nxt_eff_md[19:16] = legal_md(3'h4, md_ff[19:16]);
        end
    end

    // Slots: 0 A, 1 B, 2 C, 3 D; a buffering register sees "disabled"
    always @* begin
        fld_val = 80'h0;
        for (n = 0; n < 5; n = n + 1) begin
            fld_val[16*n +: 4] = ioab_ff[8*n +: 4];
            fld_val[16*n+4 +: 4] = ioab_ff[8*n+4 +: 4];
        end
        // C from low nibble, D from high nibble of the second register
        fld_val[11:8] = bfa_ff[0] ? 4'h0 : iocd_ff[3:0];
        fld_val[15:12] = bfb_ff[0] ? 4'h0 : iocd_ff[7:4];
        fld_val[59:56] = bfa_ff[3] ? 4'h0 : iocd_ff[11:8];
        fld_val[63:60] = bfb_ff[3] ? 4'h0 : iocd_ff[15:12];
        fld_val[75:72] = bfa_ff[4] ? 4'h0 : iocd_ff[19:16];
        fld_val[79:76] = bfb_ff[4] ? 4'h0 : iocd_ff[23:20];
    end

    // One decoder per field; channels 1,2 C and D slots stay zero
    genvar g;
    generate
        for (g = 0; g < 20; g = g + 1) begin : gen_fld
            tmcic_io_decode u_dec (
                .field_i(fld_val[4*g +: 4]),
                .cmp_en_o(dec_cmp_en[g]),
                .init_lvl_o(dec_init_lvl[g]),
                .cmp_act_o(dec_cmp_act[2*g +: 2]),
                .cap_en_o(dec_cap_en[g]),
                .cap_edge_o(dec_cap_edge[2*g +: 2])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    // Output registers

    // Everything leaves through a flop, one cycle behind the config
    always @(posedge mclk_i) begin
        if (sys_rst_i) begin
            cnt_en_ff <= 4'h0;
            eff_md_ff <= 20'h0;
            bfa_out_ff <= 5'h0;
            bfb_out_ff <= 5'h0;
            follow_ff <= 1'b0;
            cmp_en_ff <= 20'h0;
            init_lvl_ff <= 20'h0;
            cmp_act_ff <= 40'h0;
            cap_en_ff <= 20'h0;
            cap_edge_ff <= 40'h0;
        end else begin
            cnt_en_ff <= nxt_cnt_en;
            eff_md_ff <= nxt_eff_md;
            bfa_out_ff <= bfa_ff;
            bfb_out_ff <= bfb_ff;
            follow_ff <= nxt_follow;
            cmp_en_ff <= dec_cmp_en;
            init_lvl_ff <= dec_init_lvl;
            cmp_act_ff <= dec_cmp_act;
            cap_en_ff <= dec_cap_en;
            cap_edge_ff <= dec_cap_edge;
        end
    end

    assign rdata_o = rdata_ff;
    assign count_en_o = cnt_en_ff;
    assign mode_field_o = eff_md_ff;
    assign buffer_pair_a_o = bfa_out_ff;
    assign buffer_pair_b_o = bfb_out_ff;
    assign ch4_follow_o = follow_ff;
    assign cmp_en_o = cmp_en_ff;
    assign init_lvl_o = init_lvl_ff;
    assign cmp_act_o = cmp_act_ff;
    assign cap_en_o = cap_en_ff;
    assign cap_edge_o = cap_edge_ff;

endmodule

`default_nettype wire

// *** verification/tmcic_chk.sv ***
// Concurrent checks on the timer configuration block ports
`default_nettype none

module tmcic_chk (
    input wire logic mclk_i,
    input wire logic sys_rst_i,
    input wire logic standby_i,
    input wire logic [4:0] addr_i,
    input wire logic [7:0] wdata_i,
    input wire logic wr_i,
    input wire logic rd_i,
    input wire logic [7:0] rdata_o,
    input wire logic [1:0] phase_cnt_i,
    input wire logic [3:0] count_en_o,
    input wire logic [19:0] mode_field_o,
    input wire logic [4:0] buffer_pair_a_o,
    input wire logic [4:0] buffer_pair_b_o,
    input wire logic ch4_follow_o,
    input wire logic [19:0] init_lvl_o,
    input wire logic [39:0] cmp_act_o,
    input wire logic [19:0] cap_en_o,
    input wire logic [39:0] cap_edge_o
);
    ////////////////////////////////////////
    // Reset masks every check
    default clocking cb @(posedge mclk_i);
    endclocking
    default disable iff (sys_rst_i);

    // Upper mode bits read one
    AST_MODE_FIXED: assert property (
        $past(rd_i) && $past(addr_i) <= 5'h04 |-> rdata_o[7:6] == 2'b11)
        else $error("fixed mode bits lost");
    // No buffer bits on channels 1,2
    AST_RED_BUF: assert property (
        $past(rd_i) && ($past(addr_i) == 5'h01 || $past(addr_i) == 5'h02)
        |-> rdata_o[5:4] == 2'b00 && buffer_pair_a_o[2:1] == 2'b00)
        else $error("buffer bits on ch1,2");
    // Buffered C slot of channel 3 and D slot of channel 0 stay silent
    AST_BUF_C: assert property (
        buffer_pair_a_o[3] && $past(buffer_pair_a_o[3])
        |-> !cap_en_o[14] && cmp_act_o[29:28] == 2'b00)
        else $error("C slot active");
    AST_BUF_D: assert property (
        buffer_pair_b_o[0] && $past(buffer_pair_b_o[0])
        |-> !cap_en_o[3] && cmp_act_o[7:6] == 2'b00)
        else $error("D slot active");
    // Channel 4 tracks channel 3 sync PWM
    AST_FOLLOW: assert property (
        ch4_follow_o == (mode_field_o[15:12] == 4'h8 || mode_field_o[15:14] == 2'b11)
        && (!ch4_follow_o || mode_field_o[19:16] == mode_field_o[15:12]))
        else $error("channel 4 follow mismatch");
    AST_CH_MODES: assert property (
        mode_field_o[3:2] != 2'b01 && mode_field_o[15:14] != 2'b01
        && mode_field_o[19:18] != 2'b01 && mode_field_o[15:12] != 4'h3
        && mode_field_o[19:16] != 4'h3)
        else $error("mode illegal on channel");
    AST_SYNC_CH3: assert property (
        !mode_field_o[3] && !mode_field_o[7] && !mode_field_o[11])
        else $error("sync PWM off channel 3");
    // Phase pulses replace channel 1 source
    AST_PHASE: assert property (
        mode_field_o[7:6] == 2'b01 && $past(mode_field_o[7:6]) == 2'b01
        |-> count_en_o[0] == $past(phase_cnt_i[0]))
        else $error("phase not routed");
    AST_WR_MODE: assert property (
        wr_i && !standby_i && addr_i == 5'h01 && !wdata_i[3] && wdata_i[3:0] != 4'h1
        |-> ##2 mode_field_o[7:4] == $past(wdata_i[3:0], 2))
        else $error("mode not applied");
    AST_IO_CMP: assert property (
        wr_i && !standby_i && addr_i == 5'h05 && !wdata_i[3]
        |-> ##2 (init_lvl_o[0] == $past(wdata_i[2], 2)
        && cmp_act_o[1:0] == $past(wdata_i[1:0], 2)))
        else $error("slot A compare wrong");
    AST_IO_CAP: assert property (
        wr_i && !standby_i && addr_i == 5'h05 && wdata_i[7:6] == 2'b10
        |-> ##2 (cap_en_o[1] && cap_edge_o[3:2]
        == ($past(wdata_i[5], 2) ? 2'b10 : {1'b0, $past(wdata_i[4], 2)})))
        else $error("slot B capture wrong");

    ////////////////////////////////////////
    // Scenarios
    CV_FOLLOW: cover property (ch4_follow_o);
    CV_PHASE: cover property (mode_field_o[7:6] == 2'b01 && count_en_o[0]);
    CV_BUF: cover property (buffer_pair_a_o[3] && buffer_pair_b_o[3]);
endmodule

bind tmcic_top tmcic_chk u_chk (
    .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .standby_i(standby_i),
    .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .rd_i(rd_i), .rdata_o(rdata_o),
    .phase_cnt_i(phase_cnt_i), .count_en_o(count_en_o), .mode_field_o(mode_field_o),
    .buffer_pair_a_o(buffer_pair_a_o), .buffer_pair_b_o(buffer_pair_b_o),
    .ch4_follow_o(ch4_follow_o), .init_lvl_o(init_lvl_o), .cmp_act_o(cmp_act_o),
    .cap_en_o(cap_en_o), .cap_edge_o(cap_edge_o)
);

`default_nettype wire

// *** verification/timer_mode_clock_io_config_test.sv ***
// Self-checking bench for the timer clock, mode and I/O configuration block
`default_nettype none

module timer_mode_clock_io_config_test;
    timeunit 1ns;
    timeprecision 1ps;

    ////////////////////////////////////////
    // Stimulus, reset asserted
    logic mclk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic standby_i = 1'b0;
    logic manual_rst_i = 1'b0;
    logic [4:0] addr_i = 5'h00;
    logic [7:0] wdata_i = 8'h00;
    logic wr_i = 1'b0;
    logic rd_i = 1'b0;
    logic pin_a = 1'b0;
    logic pin_b = 1'b0;
    logic pin_c = 1'b0;
    logic wrap = 1'b0;
    logic [1:0] phase = 2'h0;
    wire [7:0] rdata_o;
    wire [3:0] count_en_o;
    wire [19:0] mode_field_o;
    wire [4:0] buf_a;
    wire [4:0] buf_b;
    wire ch4_follow_o;
    wire [19:0] cmp_en_o;
    wire [19:0] init_lvl_o;
    wire [39:0] cmp_act_o;
    wire [19:0] cap_en_o;
    wire [39:0] cap_edge_o;
    int err_total = 0;
    int total_checks = 0;
    int cycles = 0;
    // Legal codes on channels 1,2; sync codes
    logic [3:0] legal [7] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6, 4'h7};
    logic [3:0] sync [4] = '{4'h8, 4'hd, 4'he, 4'hf};

    tmcic_top u_dut (
        .mclk_i(mclk_i), .sys_rst_i(sys_rst_i), .standby_i(standby_i),
        .manual_rst_i(manual_rst_i), .addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i),
        .rd_i(rd_i), .rdata_o(rdata_o), .ext_clock_pin_a_i(pin_a),
        .ext_clock_pin_b_i(pin_b), .ext_clock_pin_c_i(pin_c),
        .channel2_count_wrap_i(wrap), .phase_cnt_i(phase), .count_en_o(count_en_o),
        .mode_field_o(mode_field_o), .buffer_pair_a_o(buf_a), .buffer_pair_b_o(buf_b),
        .ch4_follow_o(ch4_follow_o), .cmp_en_o(cmp_en_o), .init_lvl_o(init_lvl_o),
        .cmp_act_o(cmp_act_o), .cap_en_o(cap_en_o), .cap_edge_o(cap_edge_o)
    );

    // 100 MHz clock
    always #5 mclk_i = ~mclk_i;

    // Hang guard
    always @(posedge mclk_i) begin
        cycles++;
        if (cycles == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    ////////////////////////////////////////
    // Shared tasks
    task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // One-cycle write strobe
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge mclk_i);
        addr_i <= a;
        wdata_i <= d;
        wr_i <= 1'b1;
        @(posedge mclk_i);
        wr_i <= 1'b0;
    endtask

    // Data stands one cycle after the strobe
    task automatic rd(input logic [4:0] a, input logic [7:0] exp);
        @(posedge mclk_i);
        addr_i <= a;
        rd_i <= 1'b1;
        @(posedge mclk_i);
        rd_i <= 1'b0;
        #1 chk(rdata_o, exp);
    endtask

    // Derived outputs land one edge after the store
    task automatic settle;
        repeat (2) @(posedge mclk_i);
        #1;
    endtask

    task automatic mdc(input int ch, input logic [3:0] code, input logic [3:0] exp);
        wr(ch[4:0], {4'h0, code});
        settle();
        chk(mode_field_o[ch*4 +: 4], exp);
    endtask

    // Count enables over n cycles; drv: a,b,c,wrap,phase; quiet tail
    task automatic ck(input int ch, input logic [2:0] code, input int n,
                      input logic [4:0] drv, input int exp);
        int c;
        logic lvl;
        logic pul;
        c = 0;
        wr(5'h0c + ch[4:0], {5'h00, code});
        settle();
        for (int i = 0; i < n; i++) begin
            lvl = (i % 8 < 4) && (i < n - 16);
            pul = (i % 8 == 0) && (i < n - 16);
            @(posedge mclk_i);
            pin_a <= drv[0] & lvl;
            pin_b <= drv[1] & lvl;
            pin_c <= drv[2] & lvl;
            wrap <= drv[3] & pul;
            phase <= {2{drv[4] & pul}};
            #1;
            if (count_en_o[ch-1] === 1'b1) c++;
        end
        chk(c, exp);
    endtask

    task automatic end_of_test;
        $display("Checks %0d, errors %0d", total_checks, err_total);
        if (err_total == 0 && total_checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    ////////////////////////////////////////
    // Main sequence
    initial begin
        repeat (12) @(posedge mclk_i);
        sys_rst_i <= 1'b0;
        // Reset values, then an unmapped slot
        for (int a = 0; a < 17; a++) rd(a[4:0], a < 5 ? 8'hc0 : 8'h00);
        rd(5'h1f, 8'h00);
        wr(5'h00, 8'h32);
        rd(5'h00, 8'hf2);
        wr(5'h01, 8'h32);
        rd(5'h01, 8'hc2);
        wr(5'h00, 8'h20);
        wr(5'h03, 8'h30);
        settle();
        chk(buf_a, 5'h08);
        chk(buf_b, 5'h09);
        // Field decode, buffered slots quiet
        wr(5'h05, 8'ha5);
        settle();
        chk({init_lvl_o[0], cmp_act_o[1:0], cmp_en_o[1:0]}, 5'b10101);
        chk({cap_en_o[1], cap_edge_o[3:2]}, 3'b110);
        wr(5'h0b, 8'h98);
        settle();
        chk(cap_en_o[15:14], 2'b00);
        wr(5'h03, 8'h00);
        settle();
        chk({cap_en_o[15:14], cap_edge_o[31:28]}, 6'b110100);
        // Manual reset keeps, standby clears
        @(posedge mclk_i);
        manual_rst_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        manual_rst_i <= 1'b0;
        rd(5'h05, 8'ha5);
        rd(5'h00, 8'he0);
        @(posedge mclk_i);
        standby_i <= 1'b1;
        repeat (3) @(posedge mclk_i);
        standby_i <= 1'b0;
        rd(5'h00, 8'hc0);
        rd(5'h0b, 8'h00);
        // Mode codes per channel
        foreach (legal[i]) begin
            mdc(1, legal[i], legal[i]);
            mdc(2, legal[i], legal[i]);
        end
        mdc(0, 4'h4, 4'h0);
        mdc(4, 4'h3, 4'h0);
        mdc(3, 4'h3, 4'h0);
        mdc(4, 4'h2, 4'h2);
        foreach (sync[i]) begin
            mdc(3, sync[i], sync[i]);
            chk({ch4_follow_o, mode_field_o[19:16]}, {1'b1, sync[i]});
        end
        mdc(3, 4'h0, 4'h0);
        chk({ch4_follow_o, mode_field_o[19:16]}, 5'h02);
        // Phase counting overrides select
        wr(5'h01, 8'h04);
        ck(1, 3'h0, 80, 5'h10, 8);
        wr(5'h01, 8'h00);
        wr(5'h02, 8'h05);
        ck(2, 3'h0, 80, 5'h10, 8);
        wr(5'h02, 8'h00);
        // Clock sources, whole periods
        ck(1, 3'h0, 16, 5'h00, 16);
        ck(1, 3'h1, 64, 5'h00, 16);
        ck(1, 3'h2, 64, 5'h00, 4);
        ck(1, 3'h3, 128, 5'h00, 2);
        ck(1, 3'h4, 80, 5'h01, 8);
        ck(1, 3'h5, 80, 5'h02, 8);
        ck(1, 3'h6, 512, 5'h00, 2);
        ck(1, 3'h7, 80, 5'h08, 8);
        ck(2, 3'h6, 80, 5'h04, 8);
        ck(2, 3'h7, 1024, 5'h00, 1);
        ck(3, 3'h4, 512, 5'h00, 2);
        ck(3, 3'h5, 1024, 5'h00, 1);
        ck(3, 3'h6, 80, 5'h01, 8);
        ck(4, 3'h7, 80, 5'h02, 8);
        ck(4, 3'h2, 64, 5'h00, 4);
        end_of_test();
    end
endmodule

`default_nettype wire
